// [core/fol_option_loader.v]
// Option area reloader, write-protect map decode and flash access control registers
// Summary of operation
// [R1] Every reset copies the option area into option status and write-protect registers.
// [R2] Only reloaded values act; new option area contents wait for next reset.
// [R3] Eight configurable bytes at even addresses, complements at following odd ones.
// [R4] Byte not inverse of complement sets load error and becomes 0xff.
// [R5] Byte and complement both 0xff skip the check, no error.
// [R6] User byte bit0 watchdog source, bit1 stop reset, bit2 standby reset.
// [R7] Each protect bit but the top one guards two 2KB pages; zero means protected.
// [R8] Bytes 0..2 cover pages 0-47; byte 3 bits 0-6 48-61, bit7 62-255.
// [R9] Read and write protection independent; clearing write protection erases nothing.
// [R10] Access control bits 2:0 select 0 to 4 wait cycles; others reserved.
// [R11] Software matches wait count to system clock band.
// [R12] Access control bit 3 enables half-cycle flash access.
// [R13] Bit 4 requests prefetch; read-only bit 5 reports prefetch active.
// [R14] Read protection on for any read guard byte except 0xa5.
// [R15] Program or erase to a protected page is rejected and flagged.
// [R16] Reserved access control bits read zero; writes ignored.
// [R17] Program and erase requests held off until reload completes.
//
// Chosen here: the plain strobed port.
`include "fol_defines.vh"
module fol_option_loader #(
  parameter PAGES = 256
) (
  input wire clk,
  input wire rst,
  input wire [5:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg [3:0] opt_addr,
  output reg opt_rd,
  input wire [7:0] opt_data,
  input wire [7:0] req_page,
  input wire req_valid,
  output reg req_grant,
  output reg req_reject,
  output reg [2:0] flash_wait_count,
  output reg half_cycle_access_on,
  output reg prefetch_active,
  output reg watchdog_source_select,
  output reg stop_entry_reset_disable,
  output reg standby_entry_reset_disable,
  output reg read_protect_on,
  output reg load_done,
  output reg irq
);
  // ************************************************************
  // Loader state machine
  // ************************************************************
  localparam ST_FETCH = 4'b0001;
  localparam ST_WAIT = 4'b0010;
  localparam ST_CHECK = 4'b0100;
  localparam ST_DONE = 4'b1000;

  reg [3:0] state_r;
  reg [4:0] idx_r;
  reg [2:0] pair_r;
  reg [7:0] val_r;
  reg [7:0] opt_r [0:`FOL_OPT_PAIRS-1];
  reg load_err_r;
  reg [31:0] wp_r;
  reg [2:0] wait_r;
  reg half_r;
  reg pref_req_r;
  reg [`FOL_IRQ_BITS-1:0] irq_stat_r;
  reg [`FOL_IRQ_BITS-1:0] irq_en_r;
  reg [7:0] mem_q;
  reg opt_rd_q;
  reg [3:0] mem_addr_q;
  wire [7:0] mem_rdata;
  wire [7:0] cfg_b;
  wire [7:0] inv_b;
  wire pair_ok;
  wire pair_blank;
  reg [31:0] rd_nxt;
  reg ev_done;
  reg ev_err;
  reg ev_viol;
  wire page_prot;
  wire [31:0] wp_hit;
  wire wr_access;
  wire wr_irq_en;
  wire wr_irq_clr;
  wire [`FOL_IRQ_BITS-1:0] irq_clr_mask;
  wire wait_code_ok;
  wire irq_nxt;
  integer k;
  genvar g;

  // Reset image of the access control register, sliced per field below
  localparam [31:0] ACCESS_RST = `FOL_ACCESS_RESET;

  // Pin data from the option array sampled once on the clock
  always @(posedge clk) begin
    mem_q <= opt_data;
    opt_rd_q <= opt_rd;
    mem_addr_q <= opt_addr;
  end

  // Raw option bytes captured for the pairwise compare
  fol_opt_mem #(.DEPTH(`FOL_OPT_BYTES), .AW(4)) u_mem (
    .clk(clk),
    .wr_en(opt_rd_q),
    .wr_addr(mem_addr_q),
    .wr_data(mem_q),
    .rd_addr({pair_r, 1'b0} | {3'h0, idx_r[0]}),
    .rd_data(mem_rdata)
  );

  // Even address is the configurable byte, odd is its complement
  assign cfg_b = val_r; // [R3]
  assign inv_b = mem_rdata; // [R3]
  assign pair_ok = (cfg_b == ~inv_b); // [R4]
  assign pair_blank = (cfg_b == `FOL_OPT_ERASED) && (inv_b == `FOL_OPT_ERASED); // [R5]

  // Fetch all bytes, then walk the pairs; runs after every reset only
  always @(posedge clk) begin
    ev_done <= 1'b0;
    ev_err <= 1'b0;
    if (rst) begin
      state_r <= ST_FETCH; // [R1]
      idx_r <= 5'h00;
      pair_r <= 3'h0;
      val_r <= 8'h00;
      opt_addr <= 4'h0;
      opt_rd <= 1'b0;
      load_err_r <= 1'b0;
      load_done <= 1'b0;
      for (k = 0; k < `FOL_OPT_PAIRS; k = k + 1) begin
        opt_r[k] <= `FOL_OPT_ERASED;
      end
    end else begin
      case (state_r)
        ST_FETCH: begin
          opt_rd <= 1'b1;
          opt_addr <= idx_r[3:0];
          if (idx_r == `FOL_OPT_BYTES) begin
            opt_rd <= 1'b0;
            idx_r <= 5'h00;
            state_r <= ST_WAIT;
          end else begin
            idx_r <= idx_r + 5'h01;
          end
        end
        ST_WAIT: begin
          // Even byte read first, its value parked while the odd one comes
          if (idx_r[0]) begin
            state_r <= ST_CHECK;
          end else begin
            if (idx_r[1]) begin
              val_r <= mem_rdata;
              idx_r <= 5'h01;
            end else begin
              idx_r <= 5'h02;
            end
          end
        end
        ST_CHECK: begin
          if (!idx_r[1]) begin
            idx_r <= 5'h03;
          end else begin
            if (pair_ok || pair_blank) begin
              opt_r[pair_r] <= cfg_b; // [R4] [R5]
            end else begin
              opt_r[pair_r] <= `FOL_OPT_ERASED; // [R4]
              load_err_r <= 1'b1; // [R4]
              ev_err <= 1'b1;
            end
            if (pair_r == `FOL_OPT_PAIRS - 1) begin
              state_r <= ST_DONE;
              load_done <= 1'b1; // [R17]
              ev_done <= 1'b1;
            end else begin
              pair_r <= pair_r + 3'h1;
              idx_r <= 5'h00;
              state_r <= ST_WAIT;
            end
          end
        end
        ST_DONE: begin
          state_r <= ST_DONE; // Holds until the next reset only
        end
        default: begin
          state_r <= ST_FETCH;
        end
      endcase
    end
  end

  // ************************************************************
  // Loaded option decode
  // ************************************************************
  // Outputs follow loaded bytes only, never the raw array
  always @(posedge clk) begin
    if (rst) begin
      watchdog_source_select <= 1'b1;
      stop_entry_reset_disable <= 1'b1;
      standby_entry_reset_disable <= 1'b1;
      read_protect_on <= 1'b1;
      wp_r <= 32'hffffffff;
    end else begin
      watchdog_source_select <= opt_r[`FOL_IDX_USER_OPT][0]; // [R2] [R6]
      stop_entry_reset_disable <= opt_r[`FOL_IDX_USER_OPT][1]; // [R6]
      standby_entry_reset_disable <= opt_r[`FOL_IDX_USER_OPT][2]; // [R6]
      read_protect_on <= (opt_r[`FOL_IDX_READ_GUARD] != `FOL_READ_OPEN); // [R14] [R9]
      wp_r <= {opt_r[`FOL_IDX_WP0+3], opt_r[`FOL_IDX_WP0+2],
               opt_r[`FOL_IDX_WP0+1], opt_r[`FOL_IDX_WP0]}; // [R1] [R9]
    end
  end

  // ************************************************************
  // Page request check
  // ************************************************************
  // Two pages per bit; everything past the last paired page shares the top bit
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_wp_hit
      if (g < 31) begin : g_pair
        assign wp_hit[g] = ({25'h0000000, req_page[7:1]} == g); // [R7] [R8]
      end else begin : g_tail
        assign wp_hit[g] = (req_page >= `FOL_WP_TAIL_PAGE); // [R8]
      end
    end
  endgenerate

  // A hit on a cleared bit guards the page; pages off the map are refused too
  assign page_prot = (|(wp_hit & ~wp_r)) || (req_page >= PAGES); // [R7]

  always @(posedge clk) begin
    ev_viol <= 1'b0;
    if (rst) begin
      req_grant <= 1'b0;
      req_reject <= 1'b0;
    end else begin
      req_grant <= 1'b0;
      req_reject <= 1'b0;
      if (req_valid && load_done) begin // [R17]
        if (page_prot) begin
          req_reject <= 1'b1; // [R15]
          ev_viol <= 1'b1; // [R15]
        end else begin
          req_grant <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // Register write decode
  // ************************************************************
  // Strobe and offset combined once so every register sees one decode
  assign wr_access = reg_wr && (reg_addr == `FOL_OFF_ACCESS_CTRL);
  assign wr_irq_en = reg_wr && (reg_addr == `FOL_OFF_IRQ_ENABLE);
  assign wr_irq_clr = reg_wr && (reg_addr == `FOL_OFF_IRQ_CLEAR);
  assign irq_clr_mask = wr_irq_clr ? reg_wdata[`FOL_IRQ_BITS-1:0] : {`FOL_IRQ_BITS{1'b0}};
  // Reserved wait codes are kept out so the flash never sees them
  assign wait_code_ok = (reg_wdata[`FOL_WAIT_MSB:`FOL_WAIT_LSB] <= `FOL_WAIT_MAX); // [R10]
  // Line stays high while any enabled status bit is set
  assign irq_nxt = |(irq_stat_r & irq_en_r);

  // ************************************************************
  // Access control, interrupts and register bus
  // ************************************************************
  always @(posedge clk) begin
    if (rst) begin
      wait_r <= ACCESS_RST[`FOL_WAIT_MSB:`FOL_WAIT_LSB];
      half_r <= ACCESS_RST[`FOL_HALF_BIT];
      pref_req_r <= ACCESS_RST[`FOL_PREF_REQ_BIT];
      irq_en_r <= {`FOL_IRQ_BITS{1'b0}};
      irq_stat_r <= {`FOL_IRQ_BITS{1'b0}};
    end else begin
      if (wr_access) begin
        if (wait_code_ok) begin
          wait_r <= reg_wdata[`FOL_WAIT_MSB:`FOL_WAIT_LSB]; // [R10] [R11]
        end
        half_r <= reg_wdata[`FOL_HALF_BIT]; // [R12]
        pref_req_r <= reg_wdata[`FOL_PREF_REQ_BIT]; // [R13] [R16]
      end
      if (wr_irq_en) begin
        irq_en_r <= reg_wdata[`FOL_IRQ_BITS-1:0];
      end
      // Set wins over a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~irq_clr_mask) | {ev_viol, ev_err, ev_done};
    end
  end

  // Flash facing controls and interrupt line, all registered
  always @(posedge clk) begin
    if (rst) begin
      flash_wait_count <= ACCESS_RST[`FOL_WAIT_MSB:`FOL_WAIT_LSB];
      half_cycle_access_on <= ACCESS_RST[`FOL_HALF_BIT];
      prefetch_active <= ACCESS_RST[`FOL_PREF_ACT_BIT];
      irq <= 1'b0;
    end else begin
      flash_wait_count <= wait_r; // [R10]
      half_cycle_access_on <= half_r; // [R12]
      prefetch_active <= pref_req_r; // [R13]
      irq <= irq_nxt;
    end
  end

  // ************************************************************
  // Register read back
  // ************************************************************
  // Read mux; key and address offsets have no register behind them and read zero
  always @* begin
    rd_nxt = 32'h00000000;
    case (reg_addr)
      `FOL_OFF_ACCESS_CTRL: begin
        rd_nxt = {26'h0, prefetch_active, pref_req_r, half_r, wait_r}; // [R16] [R13]
      end
      `FOL_OFF_OPT_CS: begin
        rd_nxt = {6'h0, opt_r[`FOL_IDX_USER1], opt_r[`FOL_IDX_USER0],
                  opt_r[`FOL_IDX_USER_OPT], read_protect_on, load_err_r}; // [R1]
      end
      `FOL_OFF_WP_STATE: begin
        rd_nxt = wp_r; // [R1]
      end
      `FOL_OFF_IRQ_STATUS: begin
        rd_nxt = {29'h0, irq_stat_r};
      end
      `FOL_OFF_IRQ_ENABLE: begin
        rd_nxt = {29'h0, irq_en_r};
      end
      `FOL_OFF_PAGE_REQ: begin
        rd_nxt = {30'h0, ~load_done, load_done};
      end
      default: begin
        rd_nxt = 32'h00000000;
      end
    endcase
  end

  // Read data valid in the cycle after the strobe only
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule // fol_option_loader

// [core/fol_defines.vh]
// Register offsets, field positions, reset values and option layout for the option loader
`ifndef FOL_DEFINES_VH
`define FOL_DEFINES_VH
// Register byte offsets
`define FOL_OFF_ACCESS_CTRL 6'h00
`define FOL_OFF_UNLOCK_KEY 6'h04
`define FOL_OFF_OPT_KEY 6'h08
`define FOL_OFF_OP_STATUS 6'h0c
`define FOL_OFF_OP_CTRL 6'h10
`define FOL_OFF_TARGET_ADDR 6'h14
`define FOL_OFF_OPT_CS 6'h1c
`define FOL_OFF_WP_STATE 6'h20
`define FOL_OFF_IRQ_STATUS 6'h24
`define FOL_OFF_IRQ_CLEAR 6'h28
`define FOL_OFF_IRQ_ENABLE 6'h2c
`define FOL_OFF_PAGE_REQ 6'h30
// Access control fields
`define FOL_WAIT_LSB 0
`define FOL_WAIT_MSB 2
`define FOL_WAIT_MAX 3'h4
`define FOL_HALF_BIT 3
`define FOL_PREF_REQ_BIT 4
`define FOL_PREF_ACT_BIT 5
`define FOL_ACCESS_RESET 32'h00000030
// Option area layout
`define FOL_OPT_BYTES 16
`define FOL_OPT_PAIRS 8
`define FOL_OPT_ERASED 8'hff
`define FOL_READ_OPEN 8'ha5
`define FOL_IDX_READ_GUARD 0
`define FOL_IDX_USER_OPT 1
`define FOL_IDX_USER0 2
`define FOL_IDX_USER1 3
`define FOL_IDX_WP0 4
`define FOL_WP_TAIL_PAGE 8'h3e
// Option control/status fields
`define FOL_OCS_LOAD_ERR_BIT 0
`define FOL_OCS_READ_PROT_BIT 1
`define FOL_OCS_USER_LSB 2
`define FOL_OCS_USER_BYTE_ZERO_LSB 10
`define FOL_OCS_USER_BYTE_ONE_LSB 18
// Interrupt status bits
`define FOL_IRQ_LOAD_DONE 0
`define FOL_IRQ_LOAD_ERR 1
`define FOL_IRQ_PROT_VIOL 2
`define FOL_IRQ_BITS 3
`endif

// [core/fol_opt_mem.v]
// Small register file that holds the sixteen option area bytes as read by the loader
module fol_opt_mem #(
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [7:0] rd_data
);
  reg [7:0] mem_r [0:DEPTH-1];

  // Registered read keeps the port timing fixed at one cycle
  always @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
    rd_data <= mem_r[rd_addr];
  end
endmodule // fol_opt_mem

// [verif/fol_opt_area_model.sv]
// Behavioural option area presenting sixteen bytes at the fetch address
module fol_opt_area_model (
  input wire logic clk,
  input wire logic [3:0] opt_addr,
  input wire logic opt_rd,
  output logic [7:0] opt_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [16];
  logic [7:0] last_r = 8'h00;
  // Pair n sits at 2n, its complement at 2n+1
  assign opt_data = opt_rd ? mem[opt_addr] : ~last_r;
  // Idle lines show no stale byte, so a late sample is caught
  always @(posedge clk) begin
    if (opt_rd) begin
      last_r <= mem[opt_addr];
    end
  end
endmodule // fol_opt_area_model

// [verif/fol_option_loader_assertions.sv]
// Concurrent checks on the option loader ports
module fol_option_loader_chk #(
  parameter PAGES = 256
) (
  input wire clk,
  input wire rst,
  input wire [5:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire [3:0] opt_addr,
  input wire opt_rd,
  input wire req_valid,
  input wire req_grant,
  input wire req_reject,
  input wire [2:0] flash_wait_count,
  input wire half_cycle_access_on,
  input wire load_done
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ***************
  // Access control
  // ***************
  wait_legal_a: assert property (flash_wait_count <= 3'h4)
    else $error("wait count above four");
  wait_copy_a: assert property ((reg_wr && reg_addr == 6'h00 && reg_wdata[2:0] <= 3'h4)
    |-> ##2 flash_wait_count == $past(reg_wdata[2:0], 2)) else $error("wait code not taken");
  wait_refuse_a: assert property ((reg_wr && reg_addr == 6'h00 && reg_wdata[2:0] > 3'h4)
    |-> ##2 flash_wait_count == $past(flash_wait_count)) else $error("reserved code taken");
  half_copy_a: assert property ((reg_wr && reg_addr == 6'h00)
    |-> ##2 half_cycle_access_on == $past(reg_wdata[3], 2)) else $error("half access wrong");
  // ***************
  // Reload and requests
  // ***************
  hold_off_a: assert property (!load_done |=> !(req_grant || req_reject))
    else $error("request answered before reload");
  grant_cause_a: assert property ((req_grant || req_reject) |-> $past(req_valid && load_done))
    else $error("answer without request");
  grant_excl_a: assert property (!(req_grant && req_reject))
    else $error("grant and reject together");
  load_bound_a: assert property ($fell(rst) |-> ##[0:100] load_done)
    else $error("reload too slow");
  load_keep_a: assert property (load_done |=> load_done)
    else $error("load done dropped");
  opt_quiet_a: assert property ((load_done && $past(load_done)) |-> !opt_rd)
    else $error("option area read after reload");
  addr_first_a: assert property ($rose(opt_rd) |-> opt_addr == 4'h0)
    else $error("fetch does not start at byte zero");
  addr_step_a: assert property ((opt_rd && $past(opt_rd))
    |-> opt_addr == $past(opt_addr) + 4'h1) else $error("fetch address skipped");
endmodule // fol_option_loader_chk

bind fol_option_loader fol_option_loader_chk #(.PAGES(PAGES)) i_fol_option_loader_chk (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .opt_addr(opt_addr), .opt_rd(opt_rd), .req_valid(req_valid), .req_grant(req_grant),
  .req_reject(req_reject), .flash_wait_count(flash_wait_count),
  .half_cycle_access_on(half_cycle_access_on), .load_done(load_done));

// [verif/fol_option_loader_tb.sv]
// Self-checking bench for the option loader and access control registers
module fol_option_loader_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, req_valid = 0;
  logic [5:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic [7:0] req_page = 0;
  wire [31:0] reg_rdata;
  wire [3:0] opt_addr;
  wire [7:0] opt_data;
  wire [2:0] flash_wait_count;
  wire opt_rd, req_grant, req_reject, half_cycle_access_on, prefetch_active, irq;
  wire watchdog_source_select, stop_entry_reset_disable, standby_entry_reset_disable;
  wire read_protect_on, load_done;
  int n_mismatch = 0, comparisons = 0, k;
  // Option image (byte 0 leftmost), option status, protect map, {rp,stb,stop,wd}
  typedef struct {logic [127:0] img; logic [31:0] ocs; logic [31:0] wp; logic [3:0] dec;} fol_row_t;
  fol_row_t rows [3] = '{
    '{128'ha55aff00ff00ff00ff00ff00ff00ff00, 32'h03fffffc, 32'hffffffff, 4'h7},
    '{128'h00fffa0512ed34000ff0ffffa5007e81, 32'h03fc4beb, 32'h7effff0f, 4'ha},
    '{128'hffff00ffffffffff00ff00ff00ff00ff, 32'h03fffc02, 32'h00000000, 4'h8}};
  always #2 clk = ~clk;
  fol_option_loader #(.PAGES(256)) i_fol_option_loader (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .opt_addr(opt_addr), .opt_rd(opt_rd),
    .opt_data(opt_data), .req_page(req_page), .req_valid(req_valid), .req_grant(req_grant),
    .req_reject(req_reject), .flash_wait_count(flash_wait_count),
    .half_cycle_access_on(half_cycle_access_on), .prefetch_active(prefetch_active),
    .watchdog_source_select(watchdog_source_select),
    .stop_entry_reset_disable(stop_entry_reset_disable),
    .standby_entry_reset_disable(standby_entry_reset_disable),
    .read_protect_on(read_protect_on), .load_done(load_done), .irq(irq));
  fol_opt_area_model i_fol_opt_area_model (
    .clk(clk), .opt_addr(opt_addr), .opt_rd(opt_rd), .opt_data(opt_data));
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Bus cycles start just after an edge, strobes one cycle long
  task automatic wr(logic [5:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(logic [5:0] a, logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1;
    check(reg_rdata, exp);
  endtask
  // Reset, then wait a bounded time for the reload
  task automatic restart(logic [127:0] img);
    for (int i = 0; i < 16; i++) i_fol_opt_area_model.mem[i] = img[127-8*i -: 8];
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    for (k = 0; load_done !== 1'b1 && k < 200; k++) @(posedge clk) #1;
    check(load_done, 1);
  endtask
  // One-cycle request; exp is {grant, reject}
  task automatic req(logic [7:0] p, logic [1:0] exp);
    @(posedge clk);
    req_page <= p;
    req_valid <= 1;
    @(posedge clk);
    req_valid <= 0;
    #1;
    for (k = 0; req_grant !== 1'b1 && req_reject !== 1'b1 && k < 4; k++) @(posedge clk) #1;
    check({req_grant, req_reject}, exp);
  endtask
  initial begin
    for (int r = 0; r < 3; r++) begin
      restart(rows[r].img);
      rd(6'h1c, rows[r].ocs);
      rd(6'h20, rows[r].wp);
      check({read_protect_on, standby_entry_reset_disable, stop_entry_reset_disable,
             watchdog_source_select}, rows[r].dec);
    end
    // New area contents stay inactive until the next reload
    for (int i = 0; i < 16; i++) i_fol_opt_area_model.mem[i] = rows[1].img[127-8*i -: 8];
    rd(6'h1c, rows[2].ocs);
    restart(rows[1].img);
    rd(6'h00, 32'h30);
    // Every wait code, then reserved code 5 which must be refused
    for (int c = 0; c < 6; c++) begin
      wr(6'h00, 32'h18 | c);
      check(flash_wait_count, (c > 4) ? 4 : c);
    end
    rd(6'h00, 32'h3c);
    check(half_cycle_access_on, 1);
    wr(6'h00, 32'hffffffc0);
    rd(6'h00, 32'h0);
    check(prefetch_active, 0);
    req(8'd7, 2'b10);
    req(8'd8, 2'b01);
    req(8'd61, 2'b10);
    req(8'd62, 2'b01);
    req(8'd255, 2'b01);
    // Sticky status, enable gates the line, clear drops it
    rd(6'h24, 32'h7);
    check(irq, 0);
    wr(6'h2c, 32'h2);
    check(irq, 1);
    wr(6'h28, 32'h2);
    check(irq, 0);
    rd(6'h24, 32'h5);
    rd(6'h3c, 32'h0);
    // Mid-run reset: a request during the reload gets no answer and no flag
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    req(8'h07, 2'b00);
    rd(6'h30, 32'h2);
    check(load_done, 0);
    for (k = 0; load_done !== 1'b1 && k < 200; k++) @(posedge clk) #1;
    rd(6'h30, 32'h1);
    rd(6'h24, 32'h3);
    rd(6'h20, rows[1].wp);
    conclude();
  end
  // Hang guard, far beyond five reloads plus the register traffic
  initial begin
    #20000;
    n_mismatch++;
    conclude();
  end
endmodule // fol_option_loader_tb
